// ==== pmw_regs.sv ====
/*
 * Power manager status and cause registers: pending flags with mask,
 * status, lock protection of the clock select, reset cause, wake cause,
 * asynchronous wake enable and the implemented-options word.
 * Assumes the reset controller holds the one-hot reset source steady
 * across reset release, and event inputs are single-cycle pulses.
 */
`timescale 1ns/1ps
module pmw_regs (
    input  wire logic                  clock,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire pmw_pkg::pmw_bus_req_t bus_req,
    input  wire pmw_pkg::pmw_events_t  events,
    output logic [31:0]                bus_rdata,
    output logic                       bus_ack,
    output logic                       irq,
    output logic [31:0]                clock_select,
    output logic                       main_clk_on_rc,
    output logic [31:0]                async_wakeup_enable
);

    // ****************************************
    // State
    // ****************************************
    pmw_pkg::pmw_state_t s_q;
    pmw_pkg::pmw_state_t s_d;

    logic        wr;
    logic        rd;
    logic        unlock_hit;
    logic        locked_ok;
    logic        select_wr;
    logic        lock_err_evt;
    logic [31:0] set_bits;
    logic [31:0] clr_bits;
    logic [31:0] status_word;
    logic [31:0] read_word;

    always_comb begin
        wr = bus_req.sel && bus_req.write;
        rd = bus_req.sel && !bus_req.write;
        unlock_hit = wr && (bus_req.addr == pmw_pkg::OFF_UNLOCK)
            && (bus_req.wdata[pmw_pkg::UNLOCK_KEY_LSB +: 8] == pmw_pkg::UNLOCK_KEY);
        // Armed only for the access right after the unlock write
        locked_ok = s_q.unlocked && (s_q.unlock_addr == pmw_pkg::OFF_CLOCK_SELECT);
        select_wr = wr && (bus_req.addr == pmw_pkg::OFF_CLOCK_SELECT) && locked_ok;
        lock_err_evt = wr && (bus_req.addr == pmw_pkg::OFF_CLOCK_SELECT) && !locked_ok;

        // Hardware set events
        set_bits = pmw_pkg::RST_ZERO;
        set_bits[pmw_pkg::BIT_ACCESS_ERROR] = lock_err_evt;
        set_bits[pmw_pkg::BIT_CLOCK_READY] = events.clock_switch_done && !select_wr;
        set_bits[pmw_pkg::BIT_CLOCK_FAILURE] = events.clock_failure;

        // Write-one-to-clear, zeros leave flags alone
        clr_bits = pmw_pkg::RST_ZERO;
        if (wr && (bus_req.addr == pmw_pkg::OFF_IRQ_CLEAR)) begin
            clr_bits = bus_req.wdata & pmw_pkg::IRQ_BITS;
        end

        status_word = pmw_pkg::RST_ZERO;
        status_word[pmw_pkg::BIT_ACCESS_ERROR] = s_q.access_error;
        status_word[pmw_pkg::BIT_CLOCK_READY] = s_q.clock_ready;
        status_word[pmw_pkg::BIT_CLOCK_FAILURE] = s_q.on_rc;
    end

    // ****************************************
    // Read decode
    // ****************************************
    always_comb begin
        read_word = pmw_pkg::RST_ZERO;
        unique case (bus_req.addr)
            pmw_pkg::OFF_CLOCK_SELECT: read_word = s_q.clock_select;
            pmw_pkg::OFF_IRQ_MASK:     read_word = s_q.interrupt_mask;
            pmw_pkg::OFF_IRQ_PENDING:  read_word = s_q.pending;
            pmw_pkg::OFF_IRQ_CLEAR:    read_word = pmw_pkg::RST_ZERO;
            pmw_pkg::OFF_STATUS:       read_word = status_word;
            pmw_pkg::OFF_RESET_CAUSE: begin
                read_word = s_q.reset_cause;
                // Read on the capture edge sees the live source
                if (!s_q.captured) begin
                    read_word = events.reset_sources & pmw_pkg::RESET_CAUSE_BITS;
                end
            end
            pmw_pkg::OFF_WAKE_SOURCE:  read_word = s_q.wake_source;
            pmw_pkg::OFF_WAKE_ENABLE:  read_word = s_q.wake_enable;
            pmw_pkg::OFF_OPTIONS:      read_word = pmw_pkg::OPTIONS_VALUE;
            default:                   read_word = pmw_pkg::RST_ZERO;
        endcase
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_d = s_q;
        s_d.ack = bus_req.sel;
        s_d.rdata = rd ? read_word : pmw_pkg::RST_ZERO;

        // Unlock lasts one access only
        if (bus_req.sel) begin
            s_d.unlocked = unlock_hit;
            s_d.unlock_addr = bus_req.wdata[9:0];
        end

        if (select_wr) begin
            s_d.clock_select = bus_req.wdata;
            s_d.clock_ready = 1'b0;
        end else if (events.clock_switch_done) begin
            s_d.clock_ready = 1'b1;
        end

        if (lock_err_evt) begin
            s_d.access_error = 1'b1;
        end
        if (events.clock_failure) begin
            s_d.on_rc = 1'b1;
        end

        if (wr && (bus_req.addr == pmw_pkg::OFF_IRQ_ENABLE)) begin
            s_d.interrupt_mask = s_q.interrupt_mask | (bus_req.wdata & pmw_pkg::IRQ_BITS);
        end else if (wr && (bus_req.addr == pmw_pkg::OFF_IRQ_DISABLE)) begin
            s_d.interrupt_mask = s_q.interrupt_mask & ~bus_req.wdata;
        end

        // Set wins over a clear in the same cycle
        s_d.pending = (s_q.pending & ~clr_bits) | set_bits;
        s_d.irq = |(s_d.pending & s_d.interrupt_mask);

        if (wr && (bus_req.addr == pmw_pkg::OFF_WAKE_ENABLE)) begin
            s_d.wake_enable = bus_req.wdata & pmw_pkg::WAKE_ENABLE_BITS;
        end

        // Latest reset source caught on the first cycle after release
        if (!s_q.captured) begin
            s_d.captured = 1'b1;
            s_d.reset_cause = events.reset_sources & pmw_pkg::RESET_CAUSE_BITS;
        end

        if (events.wake_event) begin
            s_d.wake_source = events.wake_sources & pmw_pkg::WAKE_SOURCE_BITS;
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_q.rdata        <= pmw_pkg::RST_ZERO;
            s_q.ack          <= 1'b0;
            s_q.irq          <= 1'b0;
            s_q.clock_select <= pmw_pkg::RST_CLOCK_SELECT;
            s_q.unlocked     <= 1'b0;
            s_q.unlock_addr  <= 10'h000;
            s_q.interrupt_mask <= pmw_pkg::RST_ZERO;
            s_q.pending      <= pmw_pkg::RST_ZERO;
            s_q.access_error <= 1'b0;
            s_q.clock_ready  <= 1'b0;
            s_q.on_rc        <= 1'b0;
            s_q.reset_cause  <= pmw_pkg::RST_ZERO;
            s_q.captured     <= 1'b0;
            s_q.wake_source  <= pmw_pkg::RST_ZERO;
            s_q.wake_enable  <= pmw_pkg::RST_WAKE_ENABLE;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        bus_rdata = s_q.rdata;
        bus_ack = s_q.ack;
        irq = s_q.irq;
        clock_select = s_q.clock_select;
        main_clk_on_rc = s_q.on_rc;
        async_wakeup_enable = s_q.wake_enable;
    end

endmodule

// ==== pmw_pkg.sv ====
/*
 * Constants, field layouts and carrier types of the power manager status,
 * reset-cause, wake-cause and wake-enable register block.
 * Assumes a single peripheral-bus clock domain and word-aligned accesses.
 */
package pmw_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [9:0] OFF_CLOCK_SELECT = 10'h000;
    localparam logic [9:0] OFF_UNLOCK       = 10'h058;
    localparam logic [9:0] OFF_IRQ_ENABLE   = 10'h0c0;
    localparam logic [9:0] OFF_IRQ_DISABLE  = 10'h0c4;
    localparam logic [9:0] OFF_IRQ_MASK     = 10'h0c8;
    localparam logic [9:0] OFF_IRQ_PENDING  = 10'h0cc;
    localparam logic [9:0] OFF_IRQ_CLEAR    = 10'h0d0;
    localparam logic [9:0] OFF_STATUS       = 10'h0d4;
    localparam logic [9:0] OFF_RESET_CAUSE  = 10'h180;
    localparam logic [9:0] OFF_WAKE_SOURCE  = 10'h184;
    localparam logic [9:0] OFF_WAKE_ENABLE  = 10'h188;
    localparam logic [9:0] OFF_OPTIONS      = 10'h3f8;

    // ****************************************
    // Field positions and masks
    // ****************************************
    localparam int          BIT_ACCESS_ERROR  = 31;
    localparam int          BIT_CLOCK_READY   = 5;
    localparam int          BIT_CLOCK_FAILURE = 0;
    localparam logic [31:0] IRQ_BITS          = 32'h8000_0021;
    localparam logic [31:0] RESET_CAUSE_BITS  = 32'h0000_299f;
    localparam logic [31:0] WAKE_SOURCE_BITS  = 32'h0003_0077;
    localparam logic [31:0] WAKE_ENABLE_BITS  = 32'h0000_0077;
    localparam int          UNLOCK_KEY_LSB    = 24;
    localparam logic [7:0]  UNLOCK_KEY        = 8'haa;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [31:0] RST_ZERO         = 32'h0000_0000;
    localparam logic [31:0] RST_CLOCK_SELECT = 32'h0000_0000;
    localparam logic [31:0] RST_WAKE_ENABLE  = 32'h0000_0000;
    localparam logic [31:0] OPTIONS_VALUE    = 32'h0000_00c3;

    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic        sel;
        logic        write;
        logic [9:0]  addr;
        logic [31:0] wdata;
    } pmw_bus_req_t;

    typedef struct packed {
        logic        clock_failure;
        logic        clock_switch_done;
        logic        wake_event;
        logic [31:0] wake_sources;
        logic [31:0] reset_sources;
    } pmw_events_t;

    typedef struct packed {
        logic [31:0] rdata;
        logic        ack;
        logic        irq;
        logic [31:0] clock_select;
        logic        unlocked;
        logic [9:0]  unlock_addr;
        logic [31:0] interrupt_mask;
        logic [31:0] pending;
        logic        access_error;
        logic        clock_ready;
        logic        on_rc;
        logic [31:0] reset_cause;
        logic        captured;
        logic [31:0] wake_source;
        logic [31:0] wake_enable;
    } pmw_state_t;

endpackage

// ==== pmw_regs_checker.sv ====
/* Concurrent checks on the status, clear, lock and wake ports of pmw_regs.
   Assumes a bind from the bench and a single clock domain. */
`timescale 1ns/1ps
module pmw_regs_checker (
    input wire logic                  clock,
    input wire logic                  rst_n,
    input wire logic                  clk_en,
    input wire pmw_pkg::pmw_bus_req_t bus_req,
    input wire pmw_pkg::pmw_events_t  events,
    input wire logic [31:0]           bus_rdata,
    input wire logic                  bus_ack,
    input wire logic                  irq,
    input wire logic [31:0]           clock_select,
    input wire logic                  main_clk_on_rc,
    input wire logic [31:0]           async_wakeup_enable
);
    logic ok_q;
    logic ok_d;
    wire logic wr = clk_en && bus_req.sel && bus_req.write;
    wire logic rd = clk_en && bus_req.sel && !bus_req.write;
    // ****************************************
    // Last access was a valid unlock
    // ****************************************
    always_comb begin
        ok_d = ok_q;
        if (clk_en && bus_req.sel) begin
            ok_d = bus_req.write && bus_req.addr == 10'h058
                && bus_req.wdata[31:24] == 8'haa && bus_req.wdata[9:0] == 10'h000;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ok_q <= 1'b0;
        end else begin
            ok_q <= ok_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    clr_zero_a: assert property (rd && bus_req.addr == 10'h0d0 ##1 clk_en |-> bus_rdata == 0)
        else $error("clear register read not zero");
    opt_word_a: assert property (rd && bus_req.addr == 10'h3f8 ##1 clk_en
        |-> bus_rdata == 32'h0000_00c3) else $error("options word wrong");
    wen_write_a: assert property (wr && bus_req.addr == 10'h188
        |=> async_wakeup_enable == ($past(bus_req.wdata) & 32'h0000_0077)) else $error("wake enable");
    wen_reset_a: assert property ($rose(rst_n) |-> async_wakeup_enable == 0)
        else $error("wake enable not zero after reset");
    rc_move_a: assert property (clk_en && events.clock_failure |=> main_clk_on_rc)
        else $error("no switch to rc");
    rc_hold_a: assert property (main_clk_on_rc |=> main_clk_on_rc)
        else $error("rc flag dropped");
    lock_drop_a: assert property (wr && bus_req.addr == 10'h000 && !ok_q |=> $stable(clock_select))
        else $error("locked write taken");
    lock_pass_a: assert property (wr && bus_req.addr == 10'h000 && ok_q
        |=> clock_select == $past(bus_req.wdata)) else $error("unlocked write lost");
    clr_all_a: assert property (wr && bus_req.addr == 10'h0d0 && bus_req.wdata == 32'hffff_ffff
        && !events.clock_failure && !events.clock_switch_done |=> !irq) else $error("irq after clear");
    ack_follow_a: assert property (clk_en |=> bus_ack == $past(bus_req.sel))
        else $error("ack does not follow request");
    cover property (wr && bus_req.addr == 10'h000 && ok_q);
    cover property (events.clock_failure);
    cover property (rd && bus_req.addr == 10'h184);
endmodule

// ==== pmw_regs_bench.sv ====
/* Self-checking bench for pmw_regs: causes, lock, pending flags, wake.
   Assumes the package and checker are compiled first. */
`timescale 1ns/1ps
module pmw_regs_bench;
    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  clk_en = 1'b1;
    pmw_pkg::pmw_bus_req_t bus_req = '0;
    pmw_pkg::pmw_events_t  events = '0;
    logic [31:0]           bus_rdata;
    logic                  bus_ack;
    logic                  irq;
    logic [31:0]           clock_select;
    logic                  main_clk_on_rc;
    logic [31:0]           async_wakeup_enable;
    logic [31:0]           rd;
    int                    failures = 0;
    int                    cmp_count = 0;
    always #12.5 clock = ~clock;
    pmw_regs u_dut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .bus_req(bus_req),
        .events(events), .bus_rdata(bus_rdata), .bus_ack(bus_ack), .irq(irq),
        .clock_select(clock_select), .main_clk_on_rc(main_clk_on_rc),
        .async_wakeup_enable(async_wakeup_enable));
    // ****************************************
    // Drivers and compare
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [9:0] a, input logic [31:0] d);
        bus_req = '{sel: 1'b1, write: w, addr: a, wdata: d};
        @(posedge clock);
        #2;
        rd = bus_rdata;
        chk({31'h0, bus_ack}, 32'h0000_0001);
    endtask
    task automatic rdchk(input logic [9:0] a, input logic [31:0] exp);
        acc(1'b0, a, 32'h0000_0000);
        chk(rd, exp);
    endtask
    task automatic pulse(input logic f, input logic s, input logic w, input logic [31:0] src);
        bus_req.sel = 1'b0;
        events = '{f, s, w, src, events.reset_sources};
        @(posedge clock);
        #2;
        events = '{1'b0, 1'b0, 1'b0, 32'h0000_0000, events.reset_sources};
    endtask
    task automatic rst(input logic [31:0] src);
        rst_n = 1'b0;
        bus_req = '0;
        events = '{1'b0, 1'b0, 1'b0, 32'h0000_0000, src};
        repeat (8) @(posedge clock);
        #2;
        rst_n = 1'b1;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_cause();
        int b[9] = '{0, 1, 2, 3, 4, 7, 8, 11, 13};
        foreach (b[i]) begin
            rst(32'h0000_0001 << b[i]);
            rdchk(10'h180, 32'h0000_0001 << b[i]);
        end
        rdchk(10'h188, 32'h0000_0000);
        rdchk(10'h0d4, 32'h0000_0000);
        rdchk(10'h3f8, 32'h0000_00c3);
        rdchk(10'h0d0, 32'h0000_0000);
        rdchk(10'h200, 32'h0000_0000);
        $display("test reset causes done");
    endtask
    task automatic t_lock();
        acc(1'b1, 10'h000, 32'h0000_0003);
        chk(clock_select, 32'h0000_0000);
        pulse(1'b0, 1'b1, 1'b0, 32'h0000_0000);
        rdchk(10'h0d4, 32'h8000_0020);
        acc(1'b1, 10'h058, 32'haa00_0000);
        acc(1'b1, 10'h000, 32'h0000_0003);
        chk(clock_select, 32'h0000_0003);
        rdchk(10'h0d4, 32'h8000_0000);
        pulse(1'b0, 1'b1, 1'b0, 32'h0000_0000);
        rdchk(10'h0d4, 32'h8000_0020);
        rdchk(10'h0cc, 32'h8000_0020);
        acc(1'b1, 10'h0d0, 32'h8000_0020);
        rdchk(10'h0cc, 32'h0000_0000);
        $display("test lock done");
    endtask
    task automatic t_irq();
        pulse(1'b1, 1'b0, 1'b0, 32'h0000_0000);
        chk({31'h0, bus_ack}, 32'h0000_0000);
        chk({31'h0, main_clk_on_rc}, 32'h0000_0001);
        rdchk(10'h0d4, 32'h8000_0021);
        rdchk(10'h0cc, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        acc(1'b1, 10'h0c0, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        rdchk(10'h0c8, 32'h0000_0001);
        acc(1'b1, 10'h0d0, 32'h0000_0000);
        rdchk(10'h0cc, 32'h0000_0001);
        acc(1'b1, 10'h0d0, 32'hffff_ffff);
        chk({31'h0, irq}, 32'h0000_0000);
        rdchk(10'h0cc, 32'h0000_0000);
        acc(1'b1, 10'h0c4, 32'hffff_ffff);
        rdchk(10'h0c8, 32'h0000_0000);
        $display("test pending flags done");
    endtask
    task automatic t_wake();
        int s[8] = '{0, 1, 2, 4, 5, 6, 16, 17};
        acc(1'b1, 10'h188, 32'hffff_ffff);
        chk(async_wakeup_enable, 32'h0000_0077);
        rdchk(10'h188, 32'h0000_0077);
        acc(1'b1, 10'h188, 32'h0000_0000);
        chk(async_wakeup_enable, 32'h0000_0000);
        foreach (s[i]) begin
            pulse(1'b0, 1'b0, 1'b1, 32'h0000_0001 << s[i]);
            rdchk(10'h184, 32'h0000_0001 << s[i]);
        end
        // Clock enable low freezes all state
        clk_en = 1'b0;
        pulse(1'b0, 1'b0, 1'b1, 32'h0001_0000);
        chk({31'h0, bus_ack}, 32'h0000_0001);
        clk_en = 1'b1;
        rdchk(10'h184, 32'h0002_0000);
        $display("test wake done");
    endtask
    task automatic test_done();
        $display("compares=%0d failures=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        t_cause();
        t_lock();
        t_irq();
        t_wake();
        test_done();
    end
    initial begin
        #(25 * 4000);
        failures++;
        test_done();
    end
endmodule
bind pmw_regs pmw_regs_checker u_chk (.clock(clock), .rst_n(rst_n), .clk_en(clk_en),
    .bus_req(bus_req), .events(events), .bus_rdata(bus_rdata), .bus_ack(bus_ack),
    .irq(irq), .clock_select(clock_select), .main_clk_on_rc(main_clk_on_rc),
    .async_wakeup_enable(async_wakeup_enable));
